// ==== two_channel_timer_count_control.sv ====
// top of the two-channel timer count clock and clear control
// What this block does
// RULE1 - three shared external clock pins as count source: pins A and B usable by either channel, pin C by channel two only
// RULE2 - each channel has a two-way pin for capture input or compare output; output enable is held off here, so the pin is input only
// RULE3 - each channel has an input-only capture pin for its second register
// RULE4 - per-channel control, counter, two general registers; shared run and lockstep registers
// RULE5 - software should change control only while the counter is stopped
// RULE6 - control bit 7 reads zero and ignores writes
// RULE7 - clear field: never, first match/capture, second match/capture, synchronous clear
// RULE8 - synchronous clear acts only when the channel lockstep bit is one
// RULE9 - edge field: 00 rising, 01 falling, 1X both edges
// RULE10 - both edges of an internal clock doubles the count rate
// RULE11 - undivided clock ignores the edge field and counts every cycle
// RULE12 - channel one sources: /1 /4 /16 /64, pins A B, /256, cascade
// RULE13 - channel two sources: as channel one for the first six, then pin C and /1024
// RULE14 - each channel picks its clock source on its own
// RULE15 - a counter counts only while its run bit is one
// RULE16 - pins are synchronised first; counter steps by one per active edge
`include "timer_count_defines.svh"
module two_channel_timer_count_control
    import timer_count_pkg::*;
#(
    parameter int CNT_WIDTH = 16
) (
    // clock and reset
    input  wire logic                         clock,
    input  wire logic                         rst_n,
    // register port
    input  wire logic [3:0]                   regAddr,
    input  wire logic [15:0]                  regWrData,
    input  wire logic                         regWrite,
    input  wire logic                         regRead,
    output logic [15:0]                       regRdData,
    // external clock pins
    input  wire timer_count_pkg::ext_clocks_t extClocks,
    // channel pins
    input  wire logic                         ch1PrimaryIoIn,
    output logic                              ch1PrimaryIoOut,
    output logic                              ch1PrimaryIoOe_n,
    input  wire logic                         ch1CaptureOnlyIn,
    input  wire logic                         ch2PrimaryIoIn,
    output logic                              ch2PrimaryIoOut,
    output logic                              ch2PrimaryIoOe_n,
    input  wire logic                         ch2CaptureOnlyIn,
    // interrupt
    output logic                              irq
);
    import timer_count_pkg::*;

    if (CNT_WIDTH < 2 || CNT_WIDTH > 16) begin : gBadWidth
        $error("CNT_WIDTH must be 2 to 16");
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    count_control_t           ctrl_r [2];
    logic [1:0]               run_r;
    logic [1:0]               lockstep_r;
    logic [CNT_WIDTH-1:0]     cnt_r [2];
    logic [CNT_WIDTH-1:0]     gra_r [2];
    logic [CNT_WIDTH-1:0]     grb_r [2];
    logic [5:0]               stat_r;
    logic [5:0]               mask_r;
    logic [`PRE_WIDTH-1:0]    pre_r;
    logic [`PRE_WIDTH-1:0]    preLast_r;
    logic [1:0]               ioOut_r;
    logic [15:0]              rdData_r;
    logic                     irq_r;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [2:0] extRise;
    logic [2:0] extFall;
    logic [3:0] capRise;
    logic [2:0] extRaw;
    logic [3:0] capRaw;
    assign extRaw = {extClocks.clockA, extClocks.clockB, extClocks.clockC};
    assign capRaw = {ch2CaptureOnlyIn, ch2PrimaryIoIn, ch1CaptureOnlyIn, ch1PrimaryIoIn};  // [RULE2] [RULE3]

    for (genvar g = 0; g < 3; g++) begin : gExt
        edge_sync uSync (  // pins cross into the clock domain before edge detection [RULE16]
            .clock   (clock),
            .rst_n   (rst_n),
            .pinIn   (extRaw[g]),
            .levelOut(),
            .rise    (extRise[g]),
            .fall    (extFall[g])
        );
    end
    for (genvar g = 0; g < 4; g++) begin : gCap
        edge_sync uSync (
            .clock   (clock),
            .rst_n   (rst_n),
            .pinIn   (capRaw[g]),
            .levelOut(),
            .rise    (capRise[g]),
            .fall    ()
        );
    end

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    // free-running so that taps keep phase no matter which channel runs
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pre_r     <= '0;
            preLast_r <= '0;
        end else begin
            pre_r     <= pre_r + 1'b1;
            preLast_r <= pre_r;
        end
    end
    logic [`PRE_WIDTH-1:0] preRise;
    logic [`PRE_WIDTH-1:0] preFall;
    assign preRise = pre_r & ~preLast_r;
    assign preFall = ~pre_r & preLast_r;

    // ----------------------------------------
    // tick selection and match events
    // ----------------------------------------
    logic [1:0] tick;
    logic [1:0] overflow;
    logic [1:0] matchA;
    logic [1:0] matchB;
    logic [1:0] clearNow;

    function automatic logic allOnes(input logic [CNT_WIDTH-1:0] v);
        return &v;
    endfunction

    for (genvar c = 0; c < 2; c++) begin : gChan
        count_tick_select #(.IS_SECOND(c == 1)) uTick (  // independent source per channel [RULE14]
            .preRise      (preRise),
            .preFall      (preFall),
            .extRise      (extRise),
            .extFall      (extFall),
            .otherOverflow(c == 0 ? overflow[1] : 1'b0),
            .clockSource  (ctrl_r[c].clockSource),
            .edgeSelect   (ctrl_r[c].edgeSelect),
            .tick         (tick[c])
        );
        assign overflow[c] = run_r[c] & tick[c] & allOnes(cnt_r[c]);
        // compare on the stepping edge; a capture pin rising edge also counts as the event
        assign matchA[c] = (run_r[c] & tick[c] & (cnt_r[c] == gra_r[c])) | capRise[2*c];
        assign matchB[c] = (run_r[c] & tick[c] & (cnt_r[c] == grb_r[c])) | capRise[2*c+1];
    end

    // clear decode shared by both channels
    function automatic logic ownClear(input count_control_t cc, input logic a, input logic b);
        return (cc.clearSource == CLR_FIRST && a) || (cc.clearSource == CLR_SECOND && b);  // [RULE7]
    endfunction

    logic [1:0] ownClr;
    assign ownClr[0] = ownClear(ctrl_r[0], matchA[0], matchB[0]);
    assign ownClr[1] = ownClear(ctrl_r[1], matchA[1], matchB[1]);
    // sync clear only between channels both in lockstep [RULE8]
    assign clearNow[0] = ownClr[0] | (ctrl_r[0].clearSource == CLR_SYNC && (&lockstep_r) && ownClr[1]);
    assign clearNow[1] = ownClr[1] | (ctrl_r[1].clearSource == CLR_SYNC && (&lockstep_r) && ownClr[0]);

    // ----------------------------------------
    // counters
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_r[0] <= '0;
            cnt_r[1] <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (regWrite && regAddr == (c == 0 ? `ADDR_CNT1 : `ADDR_CNT2)) begin
                    cnt_r[c] <= regWrData[CNT_WIDTH-1:0];
                end else if (run_r[c]) begin  // stopped while its run bit is zero [RULE15]
                    if (clearNow[c]) begin
                        cnt_r[c] <= '0;  // [RULE7]
                    end else if (tick[c]) begin
                        cnt_r[c] <= cnt_r[c] + 1'b1;  // [RULE16]
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // control, run, lockstep and general registers
    // ----------------------------------------
    // writing control while running is allowed but may glitch a tick; software should stop first
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_r[0]  <= `CTRL_RESET;
            ctrl_r[1]  <= `CTRL_RESET;
            run_r      <= 2'h0;
            lockstep_r <= 2'h0;
        end else if (regWrite) begin
            if (regAddr == `ADDR_CTRL1) begin
                ctrl_r[0] <= regWrData[7:0] & `CTRL_WR_MASK;  // top bit held zero [RULE6]
            end
            if (regAddr == `ADDR_CTRL2) begin
                ctrl_r[1] <= regWrData[7:0] & `CTRL_WR_MASK;  // [RULE6]
            end
            if (regAddr == `ADDR_RUN) begin
                run_r <= regWrData[1:0];  // shared run register [RULE4]
            end
            if (regAddr == `ADDR_LOCKSTEP) begin
                lockstep_r <= regWrData[1:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int c = 0; c < 2; c++) begin
                gra_r[c] <= {CNT_WIDTH{1'b1}};
                grb_r[c] <= {CNT_WIDTH{1'b1}};
            end
        end else if (regWrite) begin
            if (regAddr == `ADDR_GRA1) gra_r[0] <= regWrData[CNT_WIDTH-1:0];
            if (regAddr == `ADDR_GRB1) grb_r[0] <= regWrData[CNT_WIDTH-1:0];
            if (regAddr == `ADDR_GRA2) gra_r[1] <= regWrData[CNT_WIDTH-1:0];
            if (regAddr == `ADDR_GRB2) grb_r[1] <= regWrData[CNT_WIDTH-1:0];
        end
    end

    // ----------------------------------------
    // primary pin: toggle on first-register match
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ioOut_r <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (run_r[c] && tick[c] && cnt_r[c] == gra_r[c]) begin
                    ioOut_r[c] <= ~ioOut_r[c];  // [RULE2]
                end
            end
        end
    end
    assign ch1PrimaryIoOut  = ioOut_r[0];
    assign ch2PrimaryIoOut  = ioOut_r[1];
    assign ch1PrimaryIoOe_n = 1'b1;  // output enable off: pin used as input until a mode register exists
    assign ch2PrimaryIoOe_n = 1'b1;

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    logic [5:0] events;
    assign events = {overflow[1], matchB[1], matchA[1], overflow[0], matchB[0], matchA[0]};
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stat_r <= 6'h00;
        end else begin
            // a new event beats a same-cycle write-one clear
            stat_r <= (stat_r & ~((regWrite && regAddr == `ADDR_IRQ_STAT) ? regWrData[5:0] : 6'h00)) | events;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mask_r <= 6'h00;
        end else if (regWrite && regAddr == `ADDR_IRQ_MASK) begin
            mask_r <= regWrData[5:0];
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & mask_r);
        end
    end
    assign irq = irq_r;

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdData_r <= 16'h0000;
        end else if (regRead) begin
            unique case (regAddr)
                `ADDR_CTRL1:    rdData_r <= {8'h00, ctrl_r[0] & `CTRL_WR_MASK};  // [RULE6]
                `ADDR_CTRL2:    rdData_r <= {8'h00, ctrl_r[1] & `CTRL_WR_MASK};
                `ADDR_RUN:      rdData_r <= {14'h0000, run_r};
                `ADDR_LOCKSTEP: rdData_r <= {14'h0000, lockstep_r};
                `ADDR_CNT1:     rdData_r <= 16'(cnt_r[0]);
                `ADDR_CNT2:     rdData_r <= 16'(cnt_r[1]);
                `ADDR_GRA1:     rdData_r <= 16'(gra_r[0]);
                `ADDR_GRB1:     rdData_r <= 16'(grb_r[0]);
                `ADDR_GRA2:     rdData_r <= 16'(gra_r[1]);
                `ADDR_GRB2:     rdData_r <= 16'(grb_r[1]);
                `ADDR_IRQ_STAT: rdData_r <= {10'h000, stat_r};
                `ADDR_IRQ_MASK: rdData_r <= {10'h000, mask_r};
                default:        rdData_r <= 16'h0000;
            endcase
        end else begin
            rdData_r <= 16'h0000;
        end
    end
    assign regRdData = rdData_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_reserved_bit_zero: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE6]
        $past(regRead) && $past(regAddr) == `ADDR_CTRL1 |-> regRdData[7] == 1'b0)
        else $error("reserved control bit read non-zero");
    a_stopped_holds: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE15]
        !run_r[0] && !(regWrite && regAddr == `ADDR_CNT1) |=> $stable(cnt_r[0]))
        else $error("channel one counter moved while stopped");
    a_undivided_counts: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE11]
        run_r[0] && ctrl_r[0].clockSource == 3'h0 && !clearNow[0] && !regWrite
        |=> cnt_r[0] == $past(cnt_r[0]) + 1'b1)
        else $error("undivided clock did not count every cycle");
    a_div4_both: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE10]
        ctrl_r[0].clockSource == 3'h1 && ctrl_r[0].edgeSelect[1] |-> tick[0] == (pre_r[0] == 1'b0))
        else $error("divide by four both edges not at half period");
    a_div1024_tick: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE13]
        ctrl_r[1].clockSource == 3'h7 && ctrl_r[1].edgeSelect == 2'h0 |-> tick[1] == (pre_r == 10'h200))
        else $error("channel two divide by 1024 tick misplaced");
    a_sync_needs_lockstep: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE8]
        run_r[0] && ctrl_r[0].clearSource == CLR_SYNC && !lockstep_r[0] && !regWrite
        |=> cnt_r[0] == $past(cnt_r[0]) + $past(tick[0]))
        else $error("synchronous clear acted without lockstep");
    a_clear_first: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE7]
        run_r[1] && ctrl_r[1].clearSource == CLR_FIRST && matchA[1] && !regWrite |=> cnt_r[1] == '0)
        else $error("first register match did not clear");
    a_clear_second: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE7]
        run_r[0] && ctrl_r[0].clearSource == CLR_SECOND && matchB[0] && !regWrite |=> cnt_r[0] == '0)
        else $error("second register match did not clear");
    a_ext_pin_tick: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE9]
        ctrl_r[1].clockSource == 3'h4 && ctrl_r[1].edgeSelect == 2'h0 |-> tick[1] == extRise[2])
        else $error("pin A rising edge not selected");
    a_ext_c_tick: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE13]
        ctrl_r[1].clockSource == 3'h6 && ctrl_r[1].edgeSelect == 2'h0 |-> tick[1] == extRise[0])
        else $error("pin C rising edge not selected");
    a_cascade_tick: assert property (@(posedge clock) disable iff (!rst_n)  // [RULE12]
        ctrl_r[0].clockSource == 3'h7 |-> tick[0] == overflow[1])
        else $error("channel one cascade tick wrong");
    a_irq_follows: assert property (@(posedge clock) disable iff (!rst_n)
        |(stat_r & mask_r) |=> irq)
        else $error("interrupt not raised");
    a_irq_drops: assert property (@(posedge clock) disable iff (!rst_n)
        !(|(stat_r & mask_r)) |=> !irq)
        else $error("interrupt not dropped");
endmodule

// ==== timer_count_defines.svh ====
// offsets, control write mask, reset values and counts for the two-channel timer
`ifndef TIMER_COUNT_DEFINES_SVH
`define TIMER_COUNT_DEFINES_SVH
`define ADDR_CTRL1      4'h0
`define ADDR_CTRL2      4'h1
`define ADDR_RUN        4'h2
`define ADDR_LOCKSTEP   4'h3
`define ADDR_CNT1       4'h4
`define ADDR_CNT2       4'h5
`define ADDR_GRA1       4'h6
`define ADDR_GRB1       4'h7
`define ADDR_GRA2       4'h8
`define ADDR_GRB2       4'h9
`define ADDR_IRQ_STAT   4'hA
`define ADDR_IRQ_MASK   4'hB
`define CTRL_WR_MASK    8'h7F
`define CTRL_RESET      8'h00
`define CNT_RESET       16'h0000
`define GR_RESET        16'hFFFF
`define DIV4_LOG        2
`define DIV16_LOG       4
`define DIV64_LOG       6
`define DIV256_LOG      8
`define DIV1024_LOG     10
`define PRE_WIDTH       10
`endif

// ==== timer_count_pkg.sv ====
// types shared by the two-channel timer files
package timer_count_pkg;
    typedef struct packed {
        logic       reserved;
        logic [1:0] clearSource;
        logic [1:0] edgeSelect;
        logic [2:0] clockSource;
    } count_control_t;
    typedef enum logic [1:0] {
        CLR_NEVER = 2'h0,
        CLR_FIRST = 2'h1,
        CLR_SECOND = 2'h2,
        CLR_SYNC = 2'h3
    } clear_source_t;
    typedef struct packed {
        logic clockA;
        logic clockB;
        logic clockC;
    } ext_clocks_t;
    typedef struct packed {
        logic overflow;
        logic matchSecond;
        logic matchFirst;
    } chan_events_t;
endpackage

// ==== edge_sync.sv ====
// two-flop synchroniser with rising and falling edge pulses
module edge_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // pin and edges
    input  wire logic pinIn,
    output logic      levelOut,
    output logic      rise,
    output logic      fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pinIn;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end
    assign levelOut = sync_r;
    assign rise     = sync_r & ~last_r;
    assign fall     = ~sync_r & last_r;
endmodule

// ==== count_tick_select.sv ====
// per-channel count-tick selection from prescaler, pins and cascade
`include "timer_count_defines.svh"
module count_tick_select #(
    parameter bit IS_SECOND = 1'b0
) (
    // prescaler taps and their edges
    input  wire logic [`PRE_WIDTH-1:0] preRise,
    input  wire logic [`PRE_WIDTH-1:0] preFall,
    // external pin edges
    input  wire logic [2:0]            extRise,
    input  wire logic [2:0]            extFall,
    // cascade and control
    input  wire logic                  otherOverflow,
    input  wire logic [2:0]            clockSource,
    input  wire logic [1:0]            edgeSelect,
    output logic                       tick
);
    function automatic logic pickEdge(input logic r, input logic f, input logic [1:0] e);
        return e[1] ? (r | f) : (e[0] ? f : r);
    endfunction
    always_comb begin
        unique case (clockSource)
            3'h0: tick = 1'b1;  // undivided clock: edge field ignored [RULE11]
            3'h1: tick = pickEdge(preRise[`DIV4_LOG-1], preFall[`DIV4_LOG-1], edgeSelect);   // [RULE10]
            3'h2: tick = pickEdge(preRise[`DIV16_LOG-1], preFall[`DIV16_LOG-1], edgeSelect);
            3'h3: tick = pickEdge(preRise[`DIV64_LOG-1], preFall[`DIV64_LOG-1], edgeSelect);
            3'h4: tick = pickEdge(extRise[2], extFall[2], edgeSelect);  // [RULE1] [RULE9]
            3'h5: tick = pickEdge(extRise[1], extFall[1], edgeSelect);
            3'h6: tick = IS_SECOND ? pickEdge(extRise[0], extFall[0], edgeSelect)
                                   : pickEdge(preRise[`DIV256_LOG-1], preFall[`DIV256_LOG-1], edgeSelect); // [RULE12] [RULE13]
            3'h7: tick = IS_SECOND ? pickEdge(preRise[`DIV1024_LOG-1], preFall[`DIV1024_LOG-1], edgeSelect)
                                   : otherOverflow;
        endcase
    end
endmodule

// ==== ext_source_model.sv ====
// far-side model: external count clocks and capture pin drivers
module ext_source_model
    import timer_count_pkg::*;
#(
    parameter int HALF = 5
) (
    // system clock
    input  wire logic                  clock,
    // capture requests: ch1 first, ch1 second, ch2 first, ch2 second
    input  wire logic [3:0]            capReq,
    // pins
    output timer_count_pkg::ext_clocks_t extClocks,
    output logic [3:0]                 capPins
);
    timeunit 1ns;
    timeprecision 1ps;
    import timer_count_pkg::*;
    int  phase [3] = '{0, 0, 0};
    logic [2:0] pinLvl_r = 3'h0;
    // ------------------------------------------------
    // free-running clocks, each its own period, off the falling edge
    // ------------------------------------------------
    always @(negedge clock) begin
        for (int i = 0; i < 3; i++) begin
            if (phase[i] == HALF + i - 1) begin
                phase[i] = 0;
                pinLvl_r[i] <= ~pinLvl_r[i];
            end else begin
                phase[i] = phase[i] + 1;
            end
        end
        capPins <= capReq;
    end
    assign extClocks = '{clockA: pinLvl_r[0], clockB: pinLvl_r[1], clockC: pinLvl_r[2]};
endmodule

// ==== tb_two_channel_timer_count_control.sv ====
// self-checking bench for the two-channel timer count control
`include "timer_count_defines.svh"
module tb_two_channel_timer_count_control;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_count_pkg::*;
    typedef struct {logic ch; logic [7:0] ctl; int cyc; int lo; int hi;} row_t;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [15:0] regRdData;
    logic [3:0]  capReq = 4'h0;
    logic [3:0]  capPins;
    logic        irq;
    logic [1:0]  oeN;
    logic [1:0]  ioOut;
    ext_clocks_t extClocks;
    int          fail_count = 0;
    int          num_checks = 0;
    logic [15:0] v;
    logic [15:0] w;
    // ------------------------------------------------
    // design, far side and clock
    // ------------------------------------------------
    two_channel_timer_count_control u_dut (
        .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .extClocks(extClocks),
        .ch1PrimaryIoIn(capPins[0]), .ch1PrimaryIoOut(ioOut[0]), .ch1PrimaryIoOe_n(oeN[0]),
        .ch1CaptureOnlyIn(capPins[1]), .ch2PrimaryIoIn(capPins[2]), .ch2PrimaryIoOut(ioOut[1]),
        .ch2PrimaryIoOe_n(oeN[1]), .ch2CaptureOnlyIn(capPins[3]), .irq(irq));
    ext_source_model u_far (.clock(clock), .capReq(capReq), .extClocks(extClocks), .capPins(capPins));
    initial forever #10 clock = ~clock;
    // ------------------------------------------------
    // bus, compare and closing tasks
    // ------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic chk_eq(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // phase of the prescaler against the run bit leaves one count of slack
    task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
        num_checks++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            fail_count++;
            $display("FAIL %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // counters stopped before control changes, as software must
    task automatic run(input logic [1:0] m, input int cyc);
        wr(`ADDR_RUN, {14'h0, m});
        repeat (cyc - 2) @(posedge clock);
        wr(`ADDR_RUN, 16'h0000);
    endtask
    // ------------------------------------------------
    // rows: channel, control value, cycles, count window
    // ------------------------------------------------
    row_t rows [13] = '{
        '{0, 8'h00, 100, 99, 101}, '{0, 8'h18, 100, 99, 101}, '{0, 8'h01, 400, 99, 101},
        '{0, 8'h09, 400, 99, 101}, '{0, 8'h11, 400, 198, 202}, '{0, 8'h02, 1600, 99, 101},
        '{0, 8'h03, 6400, 99, 101}, '{0, 8'h06, 2560, 9, 11}, '{1, 8'h07, 10240, 9, 11},
        '{1, 8'h04, 1680, 167, 169}, '{0, 8'h05, 1680, 139, 141}, '{1, 8'h06, 1680, 119, 121},
        '{0, 8'h14, 1680, 334, 338}};
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rd(`ADDR_CTRL1, v);
        chk_eq(v, 16'h0000);
        rd(`ADDR_GRB2, v);
        chk_eq(v, 16'hFFFF);
        chk_eq({14'h0, oeN}, 16'h0003);
        wr(`ADDR_CTRL1, 16'h00FF);
        rd(`ADDR_CTRL1, v);
        chk_eq(v, 16'h007F);
        rd(4'hF, v);
        chk_eq(v, 16'h0000);
        foreach (rows[i]) begin
            wr(`ADDR_CTRL1, 16'h0000);
            wr(`ADDR_CTRL2, 16'h0000);
            wr(`ADDR_CNT1, 16'h0000);
            wr(`ADDR_CNT2, 16'h0000);
            wr(rows[i].ch ? `ADDR_CTRL2 : `ADDR_CTRL1, {8'h00, rows[i].ctl});
            run(rows[i].ch ? 2'h2 : 2'h1, rows[i].cyc);
            rd(rows[i].ch ? `ADDR_CNT2 : `ADDR_CNT1, v);
            chk_rng(v, rows[i].lo, rows[i].hi);
            rd(rows[i].ch ? `ADDR_CNT1 : `ADDR_CNT2, w);
            chk_eq(w, 16'h0000);
            repeat (10) @(posedge clock);
            rd(rows[i].ch ? `ADDR_CNT2 : `ADDR_CNT1, w);
            chk_eq(w, v);
        end
        // cascade: ch2 wraps once, ch1 steps once
        wr(`ADDR_CTRL1, 16'h0007);
        wr(`ADDR_CNT1, 16'h0000);
        wr(`ADDR_CNT2, 16'hFFFE);
        run(2'h3, 6);
        rd(`ADDR_CNT1, v);
        chk_eq(v, 16'h0001);
        chk_eq({15'h0, ioOut[1]}, 16'h0001);
        // clear on first and second register match
        wr(`ADDR_GRA1, 16'h0009);
        wr(`ADDR_GRB1, 16'h0009);
        for (int k = 1; k < 3; k++) begin
            wr(`ADDR_CNT1, 16'h0000);
            wr(`ADDR_CTRL1, 16'(k << 5));
            run(2'h1, 15);
            rd(`ADDR_CNT1, v);
            chk_rng(v, 0, 9);
            chk_eq({15'h0, ioOut[0]}, 16'(k & 1));
        end
        // synchronous clear, with and without lockstep
        wr(`ADDR_GRA2, 16'h0009);
        wr(`ADDR_CTRL2, 16'h0020);
        wr(`ADDR_CTRL1, 16'h0060);
        for (int k = 0; k < 2; k++) begin
            wr(`ADDR_LOCKSTEP, k ? 16'h0000 : 16'h0003);
            wr(`ADDR_CNT1, 16'h0000);
            wr(`ADDR_CNT2, 16'h0000);
            run(2'h3, 25);
            rd(`ADDR_CNT1, v);
            chk_rng(v, k ? 24 : 0, k ? 26 : 9);
        end
        // capture pins clear the counter
        wr(`ADDR_LOCKSTEP, 16'h0000);
        wr(`ADDR_GRA1, 16'hFFFF);
        wr(`ADDR_GRB1, 16'hFFFF);
        for (int k = 0; k < 2; k++) begin
            wr(`ADDR_CTRL1, 16'((k + 1) << 5));
            wr(`ADDR_CNT1, 16'h0000);
            wr(`ADDR_RUN, 16'h0001);
            repeat (50) @(posedge clock);
            capReq <= 4'(1 << k);
            repeat (4) @(posedge clock);
            capReq <= 4'h0;
            run(2'h1, 10);
            rd(`ADDR_CNT1, v);
            chk_rng(v, 5, 20);
        end
        // overflow interrupt: masked, unmasked, cleared
        wr(`ADDR_IRQ_STAT, 16'h003F);
        wr(`ADDR_CTRL1, 16'h0000);
        wr(`ADDR_CNT1, 16'hFFFE);
        run(2'h1, 5);
        rd(`ADDR_IRQ_STAT, v);
        chk_eq(v & 16'h0004, 16'h0004);
        chk_eq({15'h0, irq}, 16'h0000);
        wr(`ADDR_IRQ_MASK, 16'h0004);
        repeat (2) @(posedge clock);
        chk_eq({15'h0, irq}, 16'h0001);
        wr(`ADDR_IRQ_STAT, 16'h003F);
        repeat (2) @(posedge clock);
        chk_eq({15'h0, irq}, 16'h0000);
        // reset mid-run stops and clears the counter
        wr(`ADDR_RUN, 16'h0001);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rd(`ADDR_RUN, v);
        chk_eq(v, 16'h0000);
        rd(`ADDR_CNT1, v);
        chk_eq(v, 16'h0000);
        tally_and_finish();
    end
    initial begin
        #(60000 * 20);
        fail_count++;
        tally_and_finish();
    end
endmodule
